/* inc/eeprom_two_wire_pkg.sv */
package eeprom_two_wire_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLOCK_MHZ = 50;
  localparam int WRITE_CYCLE_TIME_US = 10000;
  localparam int WRITE_CYCLE_TIME_LOW_VOLT_US = 20000;
  // microseconds times clock MHz: exact whole cycles, no rounding
  localparam int PROGRAMMING_CYCLE_CYCLES = WRITE_CYCLE_TIME_US * CLOCK_MHZ;
  localparam int PROGRAMMING_CYCLE_LOW_VOLT_CYCLES = WRITE_CYCLE_TIME_LOW_VOLT_US * CLOCK_MHZ;
  localparam int COUNT_WIDTH = 24;

  // ----------------------------------------
  // layout
  // ----------------------------------------
  localparam int ADDRESS_WIDTH = 15;
  localparam int PAGE_INDEX_WIDTH = 6;
  localparam int PAGE_BYTES = 64;
  localparam int WORD_BITS = 8;
  localparam int PIN_COUNT = 5;
  localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
  localparam logic [3:0] TYPE_PATTERN = 4'ha;
  localparam logic [6:0] OTP_ROW = 7'h7f;

  // pin vector positions
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_WP = 2;
  localparam int PIN_STRAP_HIGH = 3;
  localparam int PIN_STRAP_LOW = 4;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_DEVICE = 3'b001,
    ST_WORD_HIGH = 3'b010,
    ST_WORD_LOW = 3'b011,
    ST_DATA = 3'b100,
    ST_IGNORE = 3'b101,
    ST_PROGRAM = 3'b110
  } phase_type;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic in_otp_region(input logic [ADDRESS_WIDTH-1:0] address);
    in_otp_region = (address[ADDRESS_WIDTH-1:WORD_BITS] == OTP_ROW);
  endfunction

  function automatic logic [ADDRESS_WIDTH-1:0] page_increment(
      input logic [ADDRESS_WIDTH-1:0] address);
    logic [PAGE_INDEX_WIDTH-1:0] low;
    low = address[PAGE_INDEX_WIDTH-1:0] + 6'h01;
    page_increment = {address[ADDRESS_WIDTH-1:PAGE_INDEX_WIDTH], low};
  endfunction

endpackage

/* inc/page_buffer_if.sv */
`timescale 1ns/1ps
interface page_buffer_if;
  import eeprom_two_wire_pkg::*;
  logic store;
  logic clear;
  logic [PAGE_INDEX_WIDTH-1:0] store_index;
  logic [WORD_BITS-1:0] store_data;
  logic [PAGE_INDEX_WIDTH-1:0] read_index;
  logic [WORD_BITS-1:0] read_data;
  logic read_valid;
  logic any_valid;

  modport writer (
    output store,
    output clear,
    output store_index,
    output store_data,
    output read_index,
    input read_data,
    input read_valid,
    input any_valid
  );

  modport buffer (
    input store,
    input clear,
    input store_index,
    input store_data,
    input read_index,
    output read_data,
    output read_valid,
    output any_valid
  );
endinterface

/* verilog/page_buffer.sv */
`timescale 1ns/1ps
module page_buffer (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  page_buffer_if.buffer port
);
  import eeprom_two_wire_pkg::*;

  logic [WORD_BITS-1:0] bytes [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid;

  // data needs no reset, only its valid mask does
  always_ff @(posedge clock) begin
    if (clock_enable && port.store) begin
      bytes[port.store_index] <= port.store_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      valid <= '0;
    end else if (clock_enable) begin
      if (port.clear) begin
        valid <= '0;
      end else if (port.store) begin
        valid[port.store_index] <= 1'b1;
      end
    end
  end

  assign port.read_data = bytes[port.read_index];
  assign port.read_valid = valid[port.read_index];
  assign port.any_valid = |valid;
endmodule

/* verilog/eeprom_two_wire_slave.sv */
`timescale 1ns/1ps
// Behaviour
// - sda change while scl high is read as start or stop, never data
// - falling sda with scl high is start; decoding begins only after it
// - rising sda with scl high is stop; device then falls back to standby, or starts programming if a page is buffered
// - words are 8 bits; device pulls sda low on the ninth clock
// - standby after reset, and after stop once programming is finished
// - first word after start is the device address with 1010 type pattern
// - two address bits must equal the two strap inputs to select device
// - last bit of the device word: one reads, zero writes
// - matching address is acknowledged; mismatch stays silent, returns to standby
// - write protect high inhibits all programming; low lets writes proceed
// - byte write: device word, two address bytes, one data byte, each acknowledged
// - stop after write starts self-timed programming; inputs ignored meanwhile
// - only low six address bits increment per byte; page row held
// - passing page end wraps to first byte of the same page
// - polling gets an acknowledge only once programming is done
// - top 256 bytes become read-only once locked; otherwise ordinary storage
// - locking needs defined strap levels; third strap ignored; check by write-read
// - write protect works whether or not the locked section is enabled
// - programming time is counted from the stop to completion
// - 64-byte pages, 15-bit word address
module eeprom_two_wire_slave #(
  parameter int PROGRAMMING_CYCLE_COUNT = eeprom_two_wire_pkg::PROGRAMMING_CYCLE_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic strap_select_high,
  input wire logic strap_select_low,
  input wire logic unused_strap_input,
  input wire logic write_protect,
  input wire logic otp_lock_request,
  output logic standby,
  output logic busy,
  output logic otp_locked,
  output logic mem_write_enable,
  output logic [eeprom_two_wire_pkg::ADDRESS_WIDTH-1:0] mem_write_address,
  output logic [eeprom_two_wire_pkg::WORD_BITS-1:0] mem_write_data
);
  import eeprom_two_wire_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic scl_prev;
  logic sda_prev;
  logic lock_meta;
  logic lock_sync;

  // straps and protect are slow levels, but still two flops before use
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pin_meta <= '1;
      pin_sync <= '1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else if (clock_enable) begin
      pin_meta <= {strap_select_low, strap_select_high, write_protect, sda_in, scl_in};
      pin_sync <= pin_meta;
      scl_prev <= pin_sync[PIN_SCL];
      sda_prev <= pin_sync[PIN_SDA];
      lock_meta <= otp_lock_request;
      lock_sync <= lock_meta;
    end
  end

  // ----------------------------------------
  // bus conditions
  // ----------------------------------------
  wire scl_level = pin_sync[PIN_SCL];
  wire sda_level = pin_sync[PIN_SDA];
  wire protect_level = pin_sync[PIN_WP];
  wire strap_high = pin_sync[PIN_STRAP_HIGH];
  wire strap_low = pin_sync[PIN_STRAP_LOW];
  wire scl_rise = scl_level & ~scl_prev;
  wire scl_fall = ~scl_level & scl_prev;
  // scl must be high on both samples, so an edge on scl never fakes one
  wire start_seen = scl_level & scl_prev & sda_prev & ~sda_level;
  wire stop_seen = scl_level & scl_prev & ~sda_prev & sda_level;

  // ----------------------------------------
  // state
  // ----------------------------------------
  phase_type state;
  phase_type next_state;
  logic ack_phase;
  logic [3:0] bit_count;
  logic [WORD_BITS-1:0] shift_reg;
  logic [WORD_BITS-1:0] address_high;
  logic [ADDRESS_WIDTH-1:0] address;
  logic [COUNT_WIDTH-1:0] program_count;

  page_buffer_if page_port ();

  page_buffer page_store (
    .clock(clock),
    .resetn(resetn),
    .clock_enable(clock_enable),
    .port(page_port.buffer)
  );

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  wire receiving = (state == ST_DEVICE) | (state == ST_WORD_HIGH) |
                   (state == ST_WORD_LOW) | (state == ST_DATA);
  wire bit_taken = receiving & scl_rise & ~ack_phase;
  wire byte_done = receiving & scl_fall & ~ack_phase & (bit_count == BIT_COUNT_FULL);
  // a read word is acknowledged too, so that acknowledge must be let go as well
  wire ack_done = (receiving | (state == ST_IGNORE)) & scl_fall & ack_phase;
  // third strap bit is a don't-care
  wire address_match = (shift_reg[7:4] == TYPE_PATTERN) &
                       (shift_reg[2] == strap_high) & (shift_reg[1] == strap_low);
  wire read_selected = shift_reg[0];
  wire locked_target = otp_locked & in_otp_region(address);
  wire write_allowed = ~protect_level & ~locked_target;
  wire [ADDRESS_WIDTH-1:0] next_address = page_increment(address);
  wire [ADDRESS_WIDTH-1:0] loaded_address =
      {address_high[ADDRESS_WIDTH-WORD_BITS-1:0], shift_reg};
  wire drain_active = (state == ST_PROGRAM) & (program_count < COUNT_WIDTH'(PAGE_BYTES));
  wire program_finish = (state == ST_PROGRAM) &
                        (program_count == COUNT_WIDTH'(PROGRAMMING_CYCLE_COUNT - 1));
  // a new start before stop abandons the unfinished page
  wire abandon = (state != ST_PROGRAM) & start_seen;
  wire in_frame = (state != ST_PROGRAM) & ~start_seen & ~stop_seen;
  wire bus_event = (state != ST_PROGRAM) & (start_seen | stop_seen);
  wire ack_word = (state != ST_DEVICE) | address_match;
  // programming and any bus condition always let go of sda
  wire ack_release = (state == ST_PROGRAM) | start_seen | stop_seen | ack_done;

  assign page_port.store = clock_enable & byte_done & (state == ST_DATA) & write_allowed;
  assign page_port.store_index = address[PAGE_INDEX_WIDTH-1:0];
  assign page_port.store_data = shift_reg;
  assign page_port.clear = clock_enable & (abandon | program_finish);
  assign page_port.read_index = program_count[PAGE_INDEX_WIDTH-1:0];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // programming outranks any bus condition: pins are ignored until it ends
  always_comb begin
    next_state = state;
    if (state == ST_PROGRAM) begin
      if (program_finish) begin
        next_state = ST_STANDBY;
      end
    end else if (start_seen) begin
      next_state = ST_DEVICE;
    end else if (stop_seen) begin
      if (page_port.any_valid) begin
        next_state = ST_PROGRAM;
      end else begin
        next_state = ST_STANDBY;
      end
    end else if (byte_done) begin
      unique case (state)
        ST_DEVICE: begin
          if (address_match) begin
            // reads are served elsewhere; this end only steps aside
            next_state = read_selected ? ST_IGNORE : ST_WORD_HIGH;
          end else begin
            next_state = ST_STANDBY;
          end
        end
        ST_WORD_HIGH: begin
          next_state = ST_WORD_LOW;
        end
        ST_WORD_LOW: begin
          next_state = ST_DATA;
        end
        ST_DATA, ST_STANDBY, ST_IGNORE, ST_PROGRAM: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= ST_STANDBY;
    end else if (clock_enable) begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // bit and phase counters
  // ----------------------------------------
  // a start or stop outside programming restarts the count, so a cut frame leaves no half byte
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ack_phase <= 1'b0;
      bit_count <= 4'h0;
    end else if (clock_enable) begin
      if (bus_event) begin
        ack_phase <= 1'b0;
        bit_count <= 4'h0;
      end else if (in_frame && ack_done) begin
        ack_phase <= 1'b0;
        bit_count <= 4'h0;
      end else if (in_frame && byte_done) begin
        ack_phase <= 1'b1;
      end else if (in_frame && bit_taken) begin
        bit_count <= bit_count + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // word assembly
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      shift_reg <= 8'h00;
    end else if (clock_enable && in_frame && bit_taken) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], sda_level};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      address_high <= 8'h00;
      address <= 15'h0000;
    end else if (clock_enable && in_frame && byte_done) begin
      if (state == ST_WORD_HIGH) begin
        address_high <= shift_reg;
      end
      if (state == ST_WORD_LOW) begin
        address <= loaded_address;
      end else if (state == ST_DATA) begin
        address <= next_address;
      end
    end
  end

  // ----------------------------------------
  // acknowledge
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sda_oe_n <= 1'b1;
    end else if (clock_enable) begin
      if (ack_release) begin
        // released while programming (polling address words get no acknowledge), on start or stop, and when the ack ends
        sda_oe_n <= 1'b1;
      end else if (byte_done && ack_word) begin
        // protected bytes are still acknowledged, just never kept
        sda_oe_n <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // programming counter
  // ----------------------------------------
  // holds while idle and is zeroed by a stop outside programming, so it cannot wrap into a false finish
  always_ff @(posedge clock) begin
    if (!resetn) begin
      program_count <= '0;
    end else if (clock_enable) begin
      if (state == ST_PROGRAM) begin
        program_count <= program_count + COUNT_WIDTH'(1);
      end else if (stop_seen) begin
        program_count <= '0;
      end
    end
  end

  // ----------------------------------------
  // programming cycle and status
  // ----------------------------------------
  // buffered page is drained in its first cycles; the row is the one last addressed
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mem_write_enable <= 1'b0;
      mem_write_address <= 15'h0000;
      mem_write_data <= 8'h00;
      otp_locked <= 1'b0;
      busy <= 1'b0;
      standby <= 1'b1;
      sda_out <= 1'b0;
    end else if (clock_enable) begin
      mem_write_enable <= drain_active & page_port.read_valid;
      mem_write_address <= {address[ADDRESS_WIDTH-1:PAGE_INDEX_WIDTH], page_port.read_index};
      mem_write_data <= page_port.read_data;
      // lock state lives in flops here, so it does not survive resetn
      if (program_finish && lock_sync) begin
        otp_locked <= 1'b1;
      end
      busy <= (state == ST_PROGRAM) & ~program_finish;
      standby <= (state == ST_STANDBY);
      sda_out <= 1'b0;
    end
  end

endmodule

/* verification/eeprom_two_wire_slave_sva.sv */
`timescale 1ns/1ps
module eeprom_two_wire_slave_sva #(
  parameter int PROGRAMMING_CYCLE_COUNT = 200
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl_in,
  input logic sda_out,
  input logic sda_oe_n,
  input logic busy,
  input logic otp_locked,
  input logic mem_write_enable,
  input logic [eeprom_two_wire_pkg::ADDRESS_WIDTH-1:0] mem_write_address
);
  import eeprom_two_wire_pkg::*;
  // ----------------------------------------
  // busy length counter
  // ----------------------------------------
  int busy_cycles;
  always_ff @(posedge clock) begin
    if (!resetn || !busy) begin
      busy_cycles <= 0;
    end else begin
      busy_cycles <= busy_cycles + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  open_drain_a: assert property (sda_out == 1'b0) else $error("sda drive not low");
  busy_quiet_a: assert property (busy |-> sda_oe_n) else $error("drives sda while busy");
  drain_window_a: assert property (
    mem_write_enable |-> busy && busy_cycles < 64) else $error("store outside window");
  // busy is cleared on the finishing count, so it stands one clock less than the count
  busy_len_a: assert property (
    $fell(busy) |-> busy_cycles == PROGRAMMING_CYCLE_COUNT - 1) else $error("busy length");
  ack_edge_a: assert property ($changed(sda_oe_n) |-> !scl_in) else $error("sda moved, scl high");
  ack_hold_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n[*4]) else $error("ack too short");
  otp_sticky_a: assert property (otp_locked |=> otp_locked) else $error("lock dropped");
  otp_guard_a: assert property (
    mem_write_enable && otp_locked |-> mem_write_address[14:8] != 7'h7f) else $error("locked write");
  page_row_a: assert property (
    mem_write_enable && $past(mem_write_enable) |-> mem_write_address[14:6] ==
    $past(mem_write_address[14:6]) && mem_write_address[5:0] > $past(mem_write_address[5:0]))
    else $error("page row or order broken");
endmodule

bind eeprom_two_wire_slave eeprom_two_wire_slave_sva #(
  .PROGRAMMING_CYCLE_COUNT(PROGRAMMING_CYCLE_COUNT)
) sva_u (
  .clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .busy(busy), .otp_locked(otp_locked), .mem_write_enable(mem_write_enable),
  .mem_write_address(mem_write_address)
);

/* verification/two_wire_master.sv */
`timescale 1ns/1ps
// ----------------------------------------
// bus master, scl still between frames
// ----------------------------------------
module two_wire_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1; // idle bus, sda released
    sda_low = 1'b0;
  end
  task automatic start_cond();
    sda_low = 1'b0;
    scl = 1'b1;
    #80 sda_low = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic stop_cond();
    scl = 1'b0;
    sda_low = 1'b1;
    #80 scl = 1'b1;
    #80 sda_low = 1'b0;
    #80;
  endtask
  task automatic recover();
    sda_low = 1'b0;
    for (int i = 0; i < 9; i++) begin
      scl = 1'b0;
      #80 scl = 1'b1;
      #80;
      if (sda === 1'b1) break;
    end
    sda_low = 1'b1; // start while scl high, then leave the bus idle
    #80 stop_cond();
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i]; // msb first, moves only with scl low
      #40 scl = 1'b1;
      #80 scl = 1'b0;
      #40;
    end
    sda_low = 1'b0;
    #120 scl = 1'b1;
    #40 ack = ~sda;
    #40 scl = 1'b0;
    #120; // device lets go late, so wait before the next bit
  endtask
endmodule

/* verification/two_wire_eeprom_slave_write_otp_tb.sv */
`timescale 1ns/1ps
module two_wire_eeprom_slave_write_otp_tb;
  import eeprom_two_wire_pkg::*;
  localparam int COUNT = 200; // short cycle keeps the run brief
  typedef struct packed {
    logic wp; logic lock; logic [7:0] dev; logic [15:0] addr; logic [7:0] data;
    logic ack; logic store;
  } row_type;
  // ----------------------------------------
  // rows: protect, lock, device, address, data, ack, stored
  // ----------------------------------------
  row_type rows [9] = '{
    '{1'b0, 1'b0, 8'ha4, 16'h0123, 8'h5a, 1'b1, 1'b1},
    '{1'b0, 1'b0, 8'hac, 16'h8abc, 8'hc3, 1'b1, 1'b1},
    '{1'b1, 1'b0, 8'ha4, 16'h0010, 8'h77, 1'b1, 1'b0},
    '{1'b0, 1'b0, 8'ha6, 16'h0010, 8'h77, 1'b0, 1'b0},
    '{1'b0, 1'b0, 8'hb4, 16'h0010, 8'h77, 1'b0, 1'b0},
    '{1'b0, 1'b1, 8'ha4, 16'h7f00, 8'h11, 1'b1, 1'b1},
    '{1'b0, 1'b0, 8'ha4, 16'h7f05, 8'h22, 1'b1, 1'b0},
    '{1'b0, 1'b0, 8'ha4, 16'h7eff, 8'h33, 1'b1, 1'b1},
    '{1'b1, 1'b0, 8'ha4, 16'h7eff, 8'h44, 1'b1, 1'b0}};
  logic clock, resetn, scl, sda_low, sda, sda_out, sda_oe_n, strap_select_high;
  logic strap_select_low, unused_strap_input, write_protect, otp_lock_request;
  logic standby, busy, otp_locked, mem_write_enable, a;
  logic [14:0] mem_write_address;
  logic [7:0] mem_write_data;
  logic [22:0] writes [$];
  int miscompares, num_checks, cycles;
  assign sda = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);
  two_wire_master master_u (.scl(scl), .sda_low(sda_low), .sda(sda));
  eeprom_two_wire_slave #(.PROGRAMMING_CYCLE_COUNT(COUNT)) dut_u (
    .clock(clock), .resetn(resetn), .clock_enable(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_select_high(strap_select_high),
    .strap_select_low(strap_select_low), .unused_strap_input(unused_strap_input),
    .write_protect(write_protect), .otp_lock_request(otp_lock_request), .standby(standby),
    .busy(busy), .otp_locked(otp_locked), .mem_write_enable(mem_write_enable),
    .mem_write_address(mem_write_address), .mem_write_data(mem_write_data));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (mem_write_enable === 1'b1) writes.push_back({mem_write_address, mem_write_data});
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (10) @(posedge clock);
    for (int k = 0; k < COUNT + 50 && busy !== 1'b0; k++) @(posedge clock);
    #1;
  endtask
  task automatic xfer(input logic [7:0] dev, input logic [15:0] addr, input int n,
                      input logic [7:0] d0, output logic ack);
    logic b;
    writes.delete();
    master_u.start_cond();
    master_u.put_byte(dev, ack);
    if (ack === 1'b1) begin
      master_u.put_byte(addr[15:8], b);
      chk(b, 1'b1);
      master_u.put_byte(addr[7:0], b);
      chk(b, 1'b1);
      for (int i = 0; i < n; i++) begin
        master_u.put_byte(d0 + 8'(i), b);
        chk(b, 1'b1);
      end
    end
    master_u.stop_cond();
  endtask
  task automatic poll(input logic exp);
    master_u.start_cond();
    master_u.put_byte(8'ha4, a);
    master_u.stop_cond();
    chk(a, exp);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    {resetn, write_protect, otp_lock_request, strap_select_low, unused_strap_input} = '0;
    strap_select_high = 1'b1;
    repeat (4) @(posedge clock);
    #1 resetn = 1'b1;
    chk({standby, busy, sda_oe_n, otp_locked, mem_write_enable}, 5'b10100);
    repeat (3) @(posedge clock);
    foreach (rows[i]) begin
      @(posedge clock);
      #1 {write_protect, otp_lock_request, unused_strap_input} = {rows[i].wp, rows[i].lock, i[0]};
      xfer(rows[i].dev, rows[i].addr, 1, rows[i].data, a);
      settle();
      chk(a, rows[i].ack);
      chk(24'(writes.size()), 24'(rows[i].store));
      if (rows[i].store) chk(writes[0], {rows[i].addr[14:0], rows[i].data});
    end
    chk(otp_locked, 1'b1);
    #1 write_protect = 1'b0;
    // more than a page from offset 3e: wraps, last two bytes overwrite
    xfer(8'ha4, 16'h1bfe, 66, 8'h10, a);
    settle();
    chk(24'(writes.size()), 24'd64);
    for (int k = 0; k < 64; k++) chk(writes[k], {15'h1bc0 + 15'(k), 8'h12 + 8'(k)});
    xfer(8'ha4, 16'h0200, 1, 8'h99, a);
    poll(1'b0);
    chk(busy, 1'b1);
    settle();
    chk(writes[0], {15'h0200, 8'h99});
    poll(1'b1);
    repeat (8) @(posedge clock);
    #1 chk(standby, 1'b1);
    master_u.start_cond();
    master_u.put_byte(8'ha5, a);
    chk(a, 1'b1);
    master_u.put_byte(8'hff, a);
    chk(a, 1'b0);
    master_u.stop_cond();
    master_u.start_cond();
    master_u.put_byte(8'ha4, a);
    @(posedge clock);
    #1 resetn = 1'b0;
    repeat (4) @(posedge clock);
    chk({sda_oe_n, otp_locked, busy}, 3'b100);
    #1 resetn = 1'b1;
    master_u.recover();
    xfer(8'ha4, 16'h7f01, 1, 8'h5a, a);
    settle();
    chk(writes[0], {15'h7f01, 8'h5a});
    stop_test();
  end
endmodule
